// ===== logic/pmc_device.sv
// device end: register slave on the host bus and clock steering
`timescale 1ns/10ps
module pmc_device
(
	pmc_bus_if.dev              BUS,
	input  wire logic           CLK,
	input  wire logic           RESET_N,
	input  wire logic           SERIAL_HOST,
	input  wire logic           MODE_6800,
	input  wire logic           PLL_LOCKED,
	input  wire logic [7:0]     MEM_RDATA,
	output pmc_pkg::pmc_src_t   CORE_CLK_SEL,
	output pmc_pkg::pmc_src_t   MEM_CLK_SEL,
	output pmc_pkg::pmc_src_t   PIX_CLK_SEL,
	output logic [2:0]          PLL_EN,
	output logic                OSC_EN,
	output logic                MEM_POWER_DOWN,
	output logic                MEM_SELF_REFRESH,
	output logic                PANEL_EN,
	output logic                INHIBIT,
	output logic [7:0]          REFRESH_CFG,
	output logic                MEM_WE,
	output logic [7:0]          MEM_WDATA
);
	import pmc_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] pin;
		logic [2:0]       lk;
		logic             lock;
		logic             act;
		logic [7:0]       idx;
		logic [7:0]       ccfg;
		logic [7:0]       pwr;
		logic [7:0]       msleep;
		logic [7:0]       refresh;
		logic [7:0]       rdata;
		logic             rd_oe;
		logic             mem_we;
		logic [7:0]       mem_wdata;
		logic [1:0]       mode;
		pmc_state_t       st;
		logic [15:0]      cnt;
		logic             osc_on;
		logic             inh;
		pmc_src_t         core;
		pmc_src_t         mclk;
		pmc_src_t         pix;
		logic [2:0]       pll;
		logic             panel;
		logic             pd;
		logic             sr;
	} pmc_dev_t;

	localparam pmc_dev_t DEV_RST = '{s1: PIN_IDLE, s2: PIN_IDLE,
		s3: PIN_IDLE, pin: PIN_IDLE, st: PMC_INIT, osc_on: 1'b1,
		inh: 1'b1, core: PMC_SRC_PLL, mclk: PMC_SRC_PLL,
		pix: PMC_SRC_PLL, pll: PLL_ALL_ON, default: '0};

	pmc_dev_t   q;
	pmc_dev_t   d;
	logic       strb;
	logic       is_rd;
	logic       act;
	logic [7:0] db;

	// register read mux for data read cycles
	function automatic logic [7:0] reg_read(input pmc_dev_t s,
		input logic [7:0] mem);
		logic [7:0] v;
		v = REG_RST;
		unique case (s.idx)
			IDX_CHIP_CFG:  v = {s.lock, s.ccfg[6:0]};
			IDX_PWR_CTRL:  v = s.pwr;
			IDX_MEM_SLEEP: v = s.msleep;
			IDX_REFRESH:   v = s.refresh;
			IDX_MEM_PORT:  v = mem;
			default:       v = REG_RST;
		endcase
		return v;
	endfunction

	// synchronisers, bus decode, registers, power state machine
	always_comb
	begin
		d = q;
		d.s1 = {BUS.osc_wake, BUS.cs_n, BUS.a0, BUS.rd_n, BUS.wr_n, BUS.db};
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < PIN_W; i++)
			if (q.s2[i] == q.s3[i])
				d.pin[i] = q.s3[i];
		d.lk = {q.lk[1:0], PLL_LOCKED};
		if (q.lk[1] == q.lk[2])
			d.lock = q.lk[2];
		db = q.pin[7:0];
		if (MODE_6800)
		begin
			strb = q.pin[P_RD];
			is_rd = q.pin[P_WR];
		end
		else
		begin
			strb = !q.pin[P_RD] || !q.pin[P_WR];
			is_rd = !q.pin[P_RD];
		end
		act = !q.pin[P_CS] && strb;
		d.act = act;
		d.mem_we = 1'b0;
		if (!act)
			d.rd_oe = 1'b0;
		if (act && !q.act)
		begin
			if (is_rd)
			begin
				d.rd_oe = 1'b1;
				if (!q.pin[P_A0])
					d.rdata = STATUS_BASE | {6'h00, q.inh, 1'b0};
				else
					d.rdata = reg_read(q, MEM_RDATA);
			end
			else if (!q.pin[P_A0])
				d.idx = db;
			else
			begin
				unique case (q.idx)
					IDX_CHIP_CFG:  d.ccfg = db;
					IDX_PWR_CTRL:  d.pwr = db & PWR_MASK;
					IDX_MEM_SLEEP: d.msleep = db;
					IDX_REFRESH:   d.refresh = db;
					IDX_MEM_PORT:
					begin
						d.mem_we = 1'b1;
						d.mem_wdata = db;
					end
					default: ;
				endcase
			end
		end
		d.cnt = q.cnt + 16'h0001;
		unique case (q.st)
			PMC_INIT:
				if (q.cnt == INIT_LAST)
					d.st = PMC_NORMAL;
			PMC_NORMAL:
			begin
				d.cnt = '0;
				if (q.pwr[BIT_ENTRY] && q.pwr[1:0] != MODE_NORMAL)
				begin
					d.mode = q.pwr[1:0];
					d.st = PMC_ENTER;
				end
			end
			PMC_ENTER:
				if (!q.pwr[BIT_ENTRY])
				begin
					d.cnt = '0;
					d.st = PMC_EXIT;
				end
				else if (q.cnt == SETTLE_LAST)
				begin
					d.st = PMC_SAVING;
					if (q.mode == MODE_SLEEP && !SERIAL_HOST)
						d.osc_on = 1'b0;
				end
			PMC_SAVING:
			begin
				d.cnt = '0;
				if (!q.pwr[BIT_ENTRY])
					d.st = PMC_EXIT;
			end
			PMC_EXIT:
				if (q.osc_on && q.lock && q.cnt >= SETTLE_LAST)
					d.st = PMC_NORMAL;
		endcase
		if (q.pin[P_WAKE] && d.st != PMC_SAVING)
			d.osc_on = 1'b1;
		d.inh = d.st == PMC_INIT || d.st == PMC_SAVING
			|| d.st == PMC_EXIT;
		// clock routing for the next state
		d.core = PMC_SRC_PLL;
		d.mclk = PMC_SRC_PLL;
		d.pix = PMC_SRC_PLL;
		d.pll = PLL_ALL_ON;
		d.panel = d.st == PMC_NORMAL;
		d.pd = 1'b0;
		d.sr = 1'b0;
		if (d.st != PMC_NORMAL && d.st != PMC_INIT)
		begin
			d.pix = PMC_SRC_STOP;
			if (d.mode == MODE_SLEEP)
			begin
				d.pd = !q.msleep[BIT_SELFREF];
				d.sr = q.msleep[BIT_SELFREF];
			end
		end
		if (d.st == PMC_EXIT)
		begin
			d.core = PMC_SRC_OSC;
			d.mclk = PMC_SRC_OSC;
		end
		if (d.st == PMC_SAVING)
		begin
			if (d.mode == MODE_STANDBY)
				d.core = PMC_SRC_OSC;
			else
			begin
				d.pll = PLL_ALL_OFF;
				d.core = SERIAL_HOST ? PMC_SRC_OSC : PMC_SRC_STOP;
				d.mclk = d.mode == MODE_SUSPEND ? PMC_SRC_OSC
					: PMC_SRC_STOP;
			end
		end
	end

	// state register
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			q <= DEV_RST;
		else
			q <= d;
	end

	// outputs straight from the state register
	assign BUS.d_dout = q.rdata;
	assign BUS.d_oe_n = !q.rd_oe;
	assign CORE_CLK_SEL = q.core;
	assign MEM_CLK_SEL = q.mclk;
	assign PIX_CLK_SEL = q.pix;
	assign PLL_EN = q.pll;
	assign OSC_EN = q.osc_on;
	assign MEM_POWER_DOWN = q.pd;
	assign MEM_SELF_REFRESH = q.sr;
	assign PANEL_EN = q.panel;
	assign INHIBIT = q.inh;
	assign REFRESH_CFG = q.refresh;
	assign MEM_WE = q.mem_we;
	assign MEM_WDATA = q.mem_wdata;
endmodule // pmc_device

// ===== logic/pmc_pkg.sv
// shared constants and types for both power mode controller ends
package pmc_pkg;
	// register indices
	localparam logic [7:0] IDX_CHIP_CFG  = 8'h01;
	localparam logic [7:0] IDX_MEM_PORT  = 8'h04;
	localparam logic [7:0] IDX_PWR_CTRL  = 8'hDF;
	localparam logic [7:0] IDX_MEM_SLEEP = 8'hE0;
	localparam logic [7:0] IDX_REFRESH   = 8'hE2;
	// fields and reset values
	localparam int         BIT_PLL_STABLE = 7;
	localparam int         BIT_ENTRY      = 7;
	localparam int         BIT_SELFREF    = 7;
	localparam int         BIT_INHIBIT    = 1;
	localparam logic [7:0] PWR_MASK       = 8'h83;
	localparam logic [7:0] PWR_ENTRY      = 8'h80;
	localparam logic [7:0] STATUS_BASE    = 8'h50;
	localparam logic [7:0] REG_RST        = 8'h00;
	localparam logic [1:0] MODE_NORMAL    = 2'h0;
	localparam logic [1:0] MODE_STANDBY   = 2'h1;
	localparam logic [1:0] MODE_SUSPEND   = 2'h2;
	localparam logic [1:0] MODE_SLEEP     = 2'h3;
	localparam logic [2:0] PLL_ALL_ON     = 3'h7;
	localparam logic [2:0] PLL_ALL_OFF    = 3'h0;
	// synchronised pin vector layout
	localparam int          PIN_W    = 13;
	localparam int          P_WAKE   = 12;
	localparam int          P_CS     = 11;
	localparam int          P_A0     = 10;
	localparam int          P_RD     = 9;
	localparam int          P_WR     = 8;
	localparam logic [12:0] PIN_IDLE = 13'h0F00;
	// timing
	localparam int          CLK_MHZ   = 10;
	localparam int          INIT_NS   = 2000;
	localparam int          SETTLE_NS = 1000;
	localparam int          PHASE_NS  = 800;
	localparam int          INIT_CYC   = (INIT_NS * CLK_MHZ + 999) / 1000;
	localparam int          SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int          PHASE_CYC  = (PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [15:0] INIT_LAST   = 16'(INIT_CYC - 1);
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
	localparam logic [7:0]  PHASE_LAST  = 8'(PHASE_CYC - 1);
	// clock source of one clock output
	typedef enum logic [1:0] {PMC_SRC_STOP, PMC_SRC_OSC, PMC_SRC_PLL}
		pmc_src_t;
	// bus cycle kinds
	typedef enum logic [1:0] {PMC_CMD_WR, PMC_STAT_RD, PMC_DATA_WR,
		PMC_DATA_RD} pmc_cyc_t;
	// device power states
	typedef enum logic [2:0] {PMC_INIT, PMC_NORMAL, PMC_ENTER,
		PMC_SAVING, PMC_EXIT} pmc_state_t;
endpackage

// ===== logic/pmc_bus_if.sv
// parallel host bus between the host end and the device end
`timescale 1ns/10ps
interface pmc_bus_if;
	logic       cs_n;
	logic       a0;
	logic       rd_n;
	logic       wr_n;
	logic       osc_wake;
	logic [7:0] h_dout;
	logic       h_oe_n;
	logic [7:0] d_dout;
	logic       d_oe_n;
	logic [7:0] db;

	// resolved data bus level, pulled high when nobody drives
	assign db = !h_oe_n ? h_dout : (!d_oe_n ? d_dout : 8'hFF);

	modport host (output cs_n, a0, rd_n, wr_n, osc_wake, h_dout, h_oe_n,
		input db);
	modport dev (input cs_n, a0, rd_n, wr_n, osc_wake, db,
		output d_dout, d_oe_n);
endinterface

// ===== logic/pmc_host.sv
// host end: bus cycle engine and power mode request sequencer
`timescale 1ns/10ps
module pmc_host
(
	pmc_bus_if.host             BUS,
	input  wire logic           CLK,
	input  wire logic           RESET_N,
	input  wire logic           SERIAL_HOST,
	input  wire logic           MODE_6800,
	input  wire logic           REQ_VALID,
	input  wire logic [1:0]     REQ_MODE,
	input  wire logic [7:0]     REFRESH_VAL,
	output logic                REQ_READY,
	output logic                DONE,
	output logic                SAVING,
	output logic                PANEL_OFF,
	output logic [7:0]          LAST_READ
);
	import pmc_pkg::*;

	typedef enum logic [3:0] {H_IDLE, H_REF_IDX, H_REF_DAT, H_PWR_IDX,
		H_PWR_SEL, H_PWR_GO, H_POLL_IN, H_X_IDX, H_X_CLR, H_POLL_OUT,
		H_CFG_IDX, H_POLL_PLL} pmc_hstep_t;

	typedef struct packed {
		pmc_hstep_t step;
		logic [1:0] ph;
		logic [7:0] cnt;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] rsp;
		logic [1:0] mode;
		logic [7:0] refresh;
		logic       done;
		logic       saving;
		logic       panel_off;
		logic       wake;
		logic       cs_n;
		logic       a0;
		logic       rd_n;
		logic       wr_n;
		logic       oe_n;
		logic [7:0] dout;
	} pmc_host_t;

	localparam pmc_host_t HOST_RST = '{step: H_IDLE, cs_n: 1'b1,
		a0: 1'b1, rd_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, default: '0};

	pmc_host_t  q;
	pmc_host_t  d;
	pmc_cyc_t   kind;
	logic [7:0] dat;
	logic       rd;

	// bus cycle for the current step, then phases and sequencing
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.s1 = BUS.db;
		d.s2 = q.s1;
		d.s3 = q.s2;
		kind = PMC_STAT_RD;
		dat = REG_RST;
		unique case (q.step)
			H_IDLE, H_POLL_IN, H_POLL_OUT: kind = PMC_STAT_RD;
			H_REF_IDX: {kind, dat} = {PMC_CMD_WR, IDX_REFRESH};
			H_REF_DAT: {kind, dat} = {PMC_DATA_WR, q.refresh};
			H_PWR_IDX, H_X_IDX: {kind, dat} = {PMC_CMD_WR, IDX_PWR_CTRL};
			H_PWR_SEL, H_X_CLR: {kind, dat} = {PMC_DATA_WR, 6'h00, q.mode};
			H_PWR_GO: {kind, dat} = {PMC_DATA_WR, PWR_ENTRY | {6'h00, q.mode}};
			H_CFG_IDX: {kind, dat} = {PMC_CMD_WR, IDX_CHIP_CFG};
			H_POLL_PLL: kind = PMC_DATA_RD;
		endcase
		rd = kind == PMC_STAT_RD || kind == PMC_DATA_RD;
		if (q.step == H_IDLE)
		begin
			d.ph = 2'h0;
			d.cnt = '0;
			if (REQ_VALID && REQ_MODE != MODE_NORMAL && !q.saving)
			begin
				d.panel_off = 1'b1;
				d.mode = REQ_MODE;
				d.refresh = REFRESH_VAL;
				d.step = REQ_MODE == MODE_SUSPEND ? H_REF_IDX : H_PWR_IDX;
			end
			else if (REQ_VALID && REQ_MODE == MODE_NORMAL && q.saving)
				d.step = H_X_IDX;
			else if (REQ_VALID)
				d.done = 1'b1;
		end
		else if (q.cnt != PHASE_LAST)
		begin
			d.cnt = q.cnt + 8'h01;
			// read byte taken at the start of hold, once the answer has
			// passed all three flops; the device keeps driving till then
			if (q.ph == 2'h2 && q.cnt == 8'h00 && rd && q.s2 == q.s3)
				d.rsp = q.s3;
		end
		else
		begin
			d.cnt = '0;
			d.ph = q.ph + 2'h1;
			if (q.ph == 2'h2)
			begin
				d.ph = 2'h0;
				unique case (q.step)
					H_REF_IDX: d.step = H_REF_DAT;
					H_REF_DAT: d.step = H_PWR_IDX;
					H_PWR_IDX: d.step = H_PWR_SEL;
					H_PWR_SEL: d.step = H_PWR_GO;
					H_PWR_GO:  d.step = H_POLL_IN;
					H_POLL_IN:
						if (q.rsp[BIT_INHIBIT])
						begin
							d.saving = 1'b1;
							d.done = 1'b1;
							d.step = H_IDLE;
						end
					H_X_IDX: d.step = H_X_CLR;
					H_X_CLR:
					begin
						d.wake = q.mode == MODE_SLEEP && !SERIAL_HOST;
						d.step = H_POLL_OUT;
					end
					H_POLL_OUT:
						if (!q.rsp[BIT_INHIBIT])
						begin
							d.wake = 1'b0;
							d.step = H_CFG_IDX;
						end
					H_CFG_IDX: d.step = H_POLL_PLL;
					H_POLL_PLL:
						if (q.rsp[BIT_PLL_STABLE])
						begin
							d.saving = 1'b0;
							d.panel_off = 1'b0;
							d.done = 1'b1;
							d.step = H_IDLE;
						end
					H_IDLE: d.step = H_IDLE;
				endcase
			end
		end
		// pin levels for the phase being entered
		d.cs_n = d.step == H_IDLE || d.ph == 2'h2;
		d.a0 = kind == PMC_DATA_WR || kind == PMC_DATA_RD;
		d.dout = dat;
		d.oe_n = rd || d.step == H_IDLE;
		if (MODE_6800)
		begin
			d.rd_n = !d.cs_n && d.ph == 2'h1;
			d.wr_n = rd;
		end
		else
		begin
			d.rd_n = !(rd && !d.cs_n && d.ph == 2'h1);
			d.wr_n = !(!rd && !d.cs_n && d.ph == 2'h1);
		end
	end

	// state register
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			q <= HOST_RST;
		else
			q <= d;
	end

	// pins and user outputs from the state register
	assign BUS.cs_n = q.cs_n;
	assign BUS.a0 = q.a0;
	assign BUS.rd_n = q.rd_n;
	assign BUS.wr_n = q.wr_n;
	assign BUS.osc_wake = q.wake;
	assign BUS.h_dout = q.dout;
	assign BUS.h_oe_n = q.oe_n;
	assign REQ_READY = q.step == H_IDLE;
	assign DONE = q.done;
	assign SAVING = q.saving;
	assign PANEL_OFF = q.panel_off;
	assign LAST_READ = q.rsp;
endmodule // pmc_host

// ===== test/pmc_bus_props.sv
// bus-level assertions on the joined host and device ends
`timescale 1ns/10ps
module pmc_bus_props
(
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       cs_n,
	input  wire logic       a0,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       h_oe_n,
	input  wire logic [7:0] d_dout,
	input  wire logic       d_oe_n
);
	import pmc_pkg::*;

	// one clock domain, quiet during reset
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	// device never fights the host for the data bus
	a_no_clash: assert property (!d_oe_n |-> h_oe_n)
		else $error("device drives while host drives");
	// device stays off the bus during write strobes
	a_write_quiet: assert property (!wr_n |-> d_oe_n)
		else $error("device drives during a write strobe");
	// device starts driving only inside a read strobe
	a_read_drive: assert property ($fell(d_oe_n) |-> !cs_n && !rd_n)
		else $error("device drive outside a read strobe");
	// a read strobe is answered within the filter delay
	a_read_answer: assert property
		($fell(rd_n) && !cs_n |-> ##[2:8] !d_oe_n)
		else $error("read strobe not answered");
	// drive ends soon after the strobe ends
	a_oe_release: assert property ($rose(rd_n) |-> ##[1:8] d_oe_n)
		else $error("device keeps driving after the strobe");
	// read data holds while driven
	a_hold_data: assert property
		(!d_oe_n && $past(!d_oe_n) |-> $stable(d_dout))
		else $error("read data changed while driven");
	// an unselected device stays off the bus
	a_idle_quiet: assert property (cs_n [*6] |-> d_oe_n)
		else $error("device drives while not selected");
	// status reads carry the fixed flags and bit0 clear
	a_status_form: assert property
		(!d_oe_n && !a0 |-> (d_dout & 8'hFD) == STATUS_BASE)
		else $error("status byte has wrong fixed bits");
endmodule // pmc_bus_props

// ===== test/pmc_tb.sv
// testbench: host and device ends joined, plus a bench-driven device
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin \
	err_total++; \
	$display("BAD t=%0t got %0h exp %0h", $time, (a), (e)); \
	end end
module pmc_tb;
	import pmc_pkg::*;

	logic       CLK = 1'b0;
	logic       RESET_N = 1'b0;
	logic       ser = 1'b0;
	logic       m68 = 1'b0;
	logic       lock = 1'b0;
	logic       req_v = 1'b0;
	logic [1:0] req_m = 2'h0;
	logic [7:0] mem_rd = 8'hC3;
	logic [7:0] wcap = 8'h00;
	logic       done;
	logic [9:0] got1;
	logic [9:0] got2;
	int         err_total = 0;
	int         checks = 0;
	localparam logic [7:0] IDX [4] = '{8'h33, IDX_PWR_CTRL, IDX_MEM_SLEEP,
		IDX_MEM_PORT};
	localparam logic [7:0] WV [4] = '{8'hA5, 8'h7F, 8'h80, 8'h3C};
	localparam logic [7:0] PRE [4] = '{8'h00, 8'h00, 8'h00, 8'hC3};
	localparam logic [7:0] POST [4] = '{8'h00, 8'h03, 8'h80, 8'hC3};

	pmc_bus_if bus1 ();
	pmc_bus_if bus2 ();

	// clock of 100 ns period
	always #50 CLK = ~CLK;

	pmc_host pmc_host_i (.BUS(bus1), .CLK(CLK), .RESET_N(RESET_N),
		.SERIAL_HOST(ser), .MODE_6800(1'b0), .REQ_VALID(req_v),
		.REQ_MODE(req_m), .REFRESH_VAL(8'h5A), .REQ_READY(),
		.DONE(done), .SAVING(), .PANEL_OFF(), .LAST_READ());
	pmc_device pmc_device_i (.BUS(bus1), .CLK(CLK), .RESET_N(RESET_N),
		.SERIAL_HOST(ser), .MODE_6800(1'b0), .PLL_LOCKED(lock),
		.MEM_RDATA(mem_rd), .CORE_CLK_SEL(), .MEM_CLK_SEL(),
		.PIX_CLK_SEL(), .PLL_EN(), .OSC_EN(), .MEM_POWER_DOWN(),
		.MEM_SELF_REFRESH(), .PANEL_EN(), .INHIBIT(), .REFRESH_CFG(),
		.MEM_WE(), .MEM_WDATA());
	pmc_device pmc_device_i2 (.BUS(bus2), .CLK(CLK), .RESET_N(RESET_N),
		.SERIAL_HOST(1'b0), .MODE_6800(m68), .PLL_LOCKED(lock),
		.MEM_RDATA(mem_rd), .CORE_CLK_SEL(), .MEM_CLK_SEL(),
		.PIX_CLK_SEL(), .PLL_EN(), .OSC_EN(), .MEM_POWER_DOWN(),
		.MEM_SELF_REFRESH(), .PANEL_EN(), .INHIBIT(), .REFRESH_CFG(),
		.MEM_WE(), .MEM_WDATA());
	pmc_bus_props pmc_bus_props_i (.CLK(CLK), .RESET_N(RESET_N),
		.cs_n(bus1.cs_n), .a0(bus1.a0), .rd_n(bus1.rd_n),
		.wr_n(bus1.wr_n), .h_oe_n(bus1.h_oe_n), .d_dout(bus1.d_dout),
		.d_oe_n(bus1.d_oe_n));

	// clock steering of each device in one word
	assign got1 = {pmc_device_i.CORE_CLK_SEL, pmc_device_i.MEM_CLK_SEL,
		pmc_device_i.PIX_CLK_SEL, pmc_device_i.PLL_EN, pmc_device_i.OSC_EN};
	assign got2 = {pmc_device_i2.CORE_CLK_SEL, pmc_device_i2.MEM_CLK_SEL,
		pmc_device_i2.PIX_CLK_SEL, pmc_device_i2.PLL_EN,
		pmc_device_i2.OSC_EN};

	// last byte the bench-driven device handed to memory
	always @(posedge CLK)
		if (pmc_device_i2.MEM_WE === 1'b1)
			wcap <= pmc_device_i2.MEM_WDATA;

	// expected clock steering per mode and host kind
	function automatic logic [9:0] clk_exp(input logic [1:0] m,
		input logic s);
		case (m)
			MODE_STANDBY: return {PMC_SRC_OSC, PMC_SRC_PLL, PMC_SRC_STOP,
				PLL_ALL_ON, 1'b1};
			MODE_SUSPEND: return {s ? PMC_SRC_OSC : PMC_SRC_STOP, PMC_SRC_OSC,
				PMC_SRC_STOP, PLL_ALL_OFF, 1'b1};
			MODE_SLEEP: return {s ? PMC_SRC_OSC : PMC_SRC_STOP, PMC_SRC_STOP,
				PMC_SRC_STOP, PLL_ALL_OFF, s};
			default: return {PMC_SRC_PLL, PMC_SRC_PLL, PMC_SRC_PLL,
				PLL_ALL_ON, 1'b1};
		endcase
	endfunction

	// counts and final word, then stop
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// a bound ran out
	task automatic hang;
		err_total++;
		give_verdict;
	endtask

	// one 8080 or 6800 cycle: setup 8, strobe 8, hold 8
	task automatic bus(input logic a, input logic rd, input logic [7:0] wd,
		output logic [7:0] q);
		@(posedge CLK);
		bus2.a0 <= a;
		bus2.cs_n <= 1'b0;
		bus2.h_dout <= wd;
		bus2.h_oe_n <= rd;
		repeat (8) @(posedge CLK);
		bus2.rd_n <= m68 | !rd;
		bus2.wr_n <= rd;
		repeat (8) @(posedge CLK);
		q = bus2.db;
		bus2.rd_n <= !m68;
		bus2.wr_n <= 1'b1;
		repeat (8) @(posedge CLK);
		bus2.cs_n <= 1'b1;
		bus2.h_oe_n <= 1'b1;
	endtask

	// index write then data write or read
	task automatic wreg(input logic [7:0] i, input logic [7:0] v);
		logic [7:0] q;
		bus(1'b0, 1'b0, i, q);
		bus(1'b1, 1'b0, v, q);
	endtask
	task automatic rreg(input logic [7:0] i, output logic [7:0] q);
		bus(1'b0, 1'b0, i, q);
		bus(1'b1, 1'b1, 8'h00, q);
	endtask

	// status reads until the inhibit bit shows v
	task automatic poll(input logic v, output logic [7:0] q);
		int n;
		n = 0;
		do bus(1'b0, 1'b1, 8'h00, q);
		while (q[BIT_INHIBIT] !== v && n++ < 60);
		if (q[BIT_INHIBIT] !== v)
			hang;
	endtask

	// one request to the host end, wait for its completion pulse
	task automatic req(input logic [1:0] m);
		int n;
		@(posedge CLK);
		req_v <= 1'b1;
		req_m <= m;
		@(posedge CLK);
		req_v <= 1'b0;
		n = 0;
		do @(posedge CLK);
		while (done !== 1'b1 && n++ < 9000);
		if (done !== 1'b1)
			hang;
		repeat (3) @(posedge CLK);
	endtask

	// main sequence
	initial
	begin
		logic [7:0] q;
		bus2.cs_n = 1'b1;
		bus2.a0 = 1'b1;
		bus2.rd_n = 1'b1;
		bus2.wr_n = 1'b1;
		bus2.osc_wake = 1'b0;
		bus2.h_dout = 8'h00;
		bus2.h_oe_n = 1'b1;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		bus(1'b0, 1'b1, 8'h00, q);
		`CHK(q, STATUS_BASE | 8'h02)
		rreg(IDX_CHIP_CFG, q);
		`CHK(q, 8'h00)
		lock <= 1'b1;
		rreg(IDX_CHIP_CFG, q);
		`CHK(q, 8'h80)
		for (int i = 0; i < 4; i++)
		begin
			rreg(IDX[i], q);
			`CHK(q, PRE[i])
			wreg(IDX[i], WV[i]);
			rreg(IDX[i], q);
			`CHK(q, POST[i])
		end
		`CHK(wcap, 8'h3C)
		$display("register test done");
		bus(1'b0, 1'b0, IDX_PWR_CTRL, q);
		bus(1'b1, 1'b0, PWR_ENTRY | 8'h03, q);
		poll(1'b1, q);
		`CHK(q, STATUS_BASE | 8'h02)
		`CHK(pmc_device_i2.MEM_SELF_REFRESH, 1'b1)
		`CHK(got2, clk_exp(MODE_SLEEP, 1'b0))
		bus(1'b1, 1'b0, PWR_ENTRY | 8'h01, q);
		`CHK(got2, clk_exp(MODE_SLEEP, 1'b0))
		bus(1'b1, 1'b0, 8'h03, q);
		bus2.osc_wake <= 1'b1;
		poll(1'b0, q);
		bus2.osc_wake <= 1'b0;
		`CHK(got2, clk_exp(MODE_NORMAL, 1'b0))
		m68 <= 1'b1;
		bus2.rd_n <= 1'b0;
		rreg(IDX_MEM_SLEEP, q);
		`CHK(q, 8'h80)
		bus(1'b0, 1'b1, 8'h00, q);
		`CHK(q, STATUS_BASE)
		$display("bench bus power test done");
		req(MODE_NORMAL);
		`CHK(got1, clk_exp(MODE_NORMAL, 1'b0))
		for (int s = 0; s < 2; s++)
			for (int m = 1; m < 4; m++)
			begin
				ser <= s[0];
				req(m[1:0]);
				`CHK(pmc_host_i.SAVING, 1'b1)
				`CHK(pmc_host_i.REQ_READY, 1'b1)
				`CHK(pmc_host_i.PANEL_OFF, 1'b1)
				`CHK(pmc_host_i.LAST_READ, STATUS_BASE | 8'h02)
				`CHK(pmc_device_i.INHIBIT, 1'b1)
				`CHK(pmc_device_i.PANEL_EN, 1'b0)
				`CHK(got1, clk_exp(m[1:0], s[0]))
				if (m == 2)
					`CHK(pmc_device_i.REFRESH_CFG, 8'h5A)
				if (m == 3)
					`CHK(pmc_device_i.MEM_POWER_DOWN, 1'b1)
				req(MODE_NORMAL);
				`CHK(got1, clk_exp(MODE_NORMAL, 1'b0))
				`CHK({pmc_device_i.INHIBIT, pmc_device_i.PANEL_EN}, 2'h1)
				`CHK(pmc_host_i.LAST_READ, 8'h80)
				`CHK({pmc_host_i.SAVING, pmc_host_i.PANEL_OFF}, 2'h0)
			end
		$display("host request test done");
		give_verdict;
	end
endmodule // pmc_tb
